// ### common/epp_pkg.sv
// Package of constants for the EEPROM program, erase and protect block.
package epp_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int OFS_W = 10;
	localparam int ARRAY_BYTES = 640;
	localparam logic [15:0] REG_BLOCK_PROTECT = 16'h0035;
	localparam logic [15:0] REG_PAGE_MAP = 16'h0037;
	localparam logic [15:0] REG_PROGRAM_CONTROL = 16'h003B;
	localparam logic [15:0] REG_CONFIG_BYTE = 16'h003F;
	localparam logic [7:0] BLOCK_PROTECT_RESET = 8'hFF;
	localparam logic [7:0] PROGRAM_CONTROL_RESET = 8'h00;
	localparam logic [3:0] PAGE_MAP_RESET = 4'h0;
	localparam logic [11:0] ARRAY_LOW = 12'hD80;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int PAGE_LSB = 4;
	// Block protect fields.
	localparam int BP_BULK = 7;
	localparam int BP_PROG = 6;
	localparam int BP_REGION4 = 5;
	localparam int BP_CONFIG = 4;
	// Program control fields.
	localparam int PC_ODD = 7;
	localparam int PC_EVEN = 6;
	localparam int PC_INHIBIT = 5;
	localparam int PC_BYTE = 4;
	localparam int PC_ROW = 3;
	localparam int PC_ERASE = 2;
	localparam int PC_LATCH = 1;
	localparam int PC_HV = 0;
	// Region upper bounds as array offsets, exclusive.
	localparam logic [9:0] REGION0_END = 10'h020;
	localparam logic [9:0] REGION1_END = 10'h060;
	localparam logic [9:0] REGION2_END = 10'h0E0;
	localparam logic [9:0] REGION3_END = 10'h200;
	localparam logic [9:0] HALF_SPLIT = 10'h140;
	localparam logic [9:0] ROW_MASK = 10'h3F0;
	// Clear window after reset, in bus clock cycles.
	localparam int CLEAR_WINDOW_CYC = 64;
	localparam int WIN_W = 7;
	typedef enum logic [1:0] {EPP_SCOPE_BULK, EPP_SCOPE_ROW, EPP_SCOPE_BYTE} epp_scope_t;
endpackage : epp_pkg

// ### core/epp_top.sv
// EEPROM program, erase and block protect control with its 640-byte array.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - Protect bits clear once, first 64 cycles; in special mode the code clears them at any time, any number of times
// RULE2 - Protect bit written one holds until reset; in special mode the code still clears it on a zero write
// RULE3 - Bulk guard refuses bulk and row erase
// RULE4 - Program guard disables all programming
// RULE5 - Config guard applies only in normal modes
// RULE6 - Five region bits guard fixed array ranges
// RULE7 - Reads ignore protection entirely
// RULE8 - Array at 0x0D80, page remappable
// RULE9 - Erased bytes read as FF
// RULE10 - Array writes ignored while voltage on
// RULE11 - Odd plus even programs half array
// RULE12 - Inhibit status bit is read only
// RULE13 - Byte and row bits pick scope
// RULE14 - Erase select freely read and written
// RULE15 - Latch bit captures writes for programming
// RULE16 - Voltage bit writable only while latched
// RULE17 - Voltage bit switches array voltage
// RULE18 - Programming ignores byte and row bits
// RULE19 - Software erase sequence with timed voltage
// RULE20 - Software program sequence 0x02 then 0x03
// RULE21 - Software picks oscillator below 1MHz
// RULE22 - Software erases before programming
// RULE23 - Pump clock select picks internal oscillator
// RULE24 - Voltage output level, software timed
// RULE25 - Protected request leaves array unchanged
module epp_top (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic special_mode_in,
	input wire logic pump_clock_select_in,
	output logic [7:0] rd_data_out,
	output logic hv_enable_out,
	output logic pump_osc_select_out
);
	logic [7:0] mem [0:epp_pkg::ARRAY_BYTES-1];
	logic [7:0] config_cell;
	logic [7:0] config_latch;
	logic config_loaded;
	logic [7:0] block_protect;
	logic [7:0] cleared_once;
	logic [7:0] set_locked;
	logic [7:0] prog_ctrl;
	logic [3:0] page_map;
	logic [epp_pkg::WIN_W-1:0] win_count;
	logic [1:0] mode_sync;
	logic [1:0] pump_sync;
	logic lat_valid;
	logic lat_cfg;
	logic [9:0] lat_ofs;
	logic [7:0] lat_data;
	logic hit_array;
	logic hit_cfg;
	logic [9:0] ofs;
	logic special;
	logic window_open;
	logic wr_bp;
	logic wr_pc;
	logic op_fire;
	logic [7:0] next_block_protect;
	logic [7:0] next_prog_ctrl;
	logic [7:0] next_rd;
	logic op_erase;
	logic op_both_rows;
	logic bulk_allowed;
	logic prog_allowed;
	logic cfg_allowed;
	logic lat_guarded;
	logic [9:0] lat_row;
	logic [4:0] region_open;
	epp_pkg::epp_scope_t op_scope;

	// Regions 0 to 3 sit on the low guard bits; region 4 sits above the config guard.
	localparam int LOW_REGIONS = 4;

	// RULE13 row of an array offset.
	function automatic logic [9:0] row_of(input logic [9:0] o);
		row_of = o & epp_pkg::ROW_MASK;
	endfunction : row_of

	function automatic logic [2:0] region_of(input logic [9:0] o);
		if (o < epp_pkg::REGION0_END) begin
			region_of = 3'h0;
		end else if (o < epp_pkg::REGION1_END) begin
			region_of = 3'h1;
		end else if (o < epp_pkg::REGION2_END) begin
			region_of = 3'h2;
		end else if (o < epp_pkg::REGION3_END) begin
			region_of = 3'h3;
		end else begin
			region_of = 3'h4;
		end
	endfunction : region_of

	// RULE6 region guard lookup.
	function automatic logic region_guarded(input logic [9:0] o, input logic [7:0] bp);
		case (region_of(o))
			3'h0: region_guarded = bp[0];
			3'h1: region_guarded = bp[1];
			3'h2: region_guarded = bp[2];
			3'h3: region_guarded = bp[3];
			default: region_guarded = bp[epp_pkg::BP_REGION4];
		endcase
	endfunction : region_guarded

	// RULE13 scope decode.
	function automatic epp_pkg::epp_scope_t scope_of(input logic [7:0] pc);
		if (pc[epp_pkg::PC_BYTE]) begin
			scope_of = epp_pkg::EPP_SCOPE_BYTE;
		end else if (pc[epp_pkg::PC_ROW]) begin
			scope_of = epp_pkg::EPP_SCOPE_ROW;
		end else begin
			scope_of = epp_pkg::EPP_SCOPE_BULK;
		end
	endfunction : scope_of

	// Mode and pump select pins come from outside, so each passes two flops first.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_sync <= 2'h0;
			pump_sync <= 2'h0;
			pump_osc_select_out <= 1'b0;
		end else begin
			mode_sync <= {mode_sync[0], special_mode_in};
			pump_sync <= {pump_sync[0], pump_clock_select_in};
			// RULE23 pump clock source.
			pump_osc_select_out <= pump_sync[1];
		end
	end

	assign special = mode_sync[1];
	// The counter stops at the limit, so it can never wrap and reopen the window.
	assign window_open = (win_count < epp_pkg::WIN_W'(epp_pkg::CLEAR_WINDOW_CYC));

	// RULE8 array address decode.
	assign ofs = 10'(addr_in[11:0] - epp_pkg::ARRAY_LOW);
	assign hit_array = (addr_in[15:12] == page_map) && (addr_in[11:0] >= epp_pkg::ARRAY_LOW);
	assign hit_cfg = (addr_in == epp_pkg::REG_CONFIG_BYTE);
	assign wr_bp = wr_en_in && (addr_in == epp_pkg::REG_BLOCK_PROTECT);
	assign wr_pc = wr_en_in && (addr_in == epp_pkg::REG_PROGRAM_CONTROL);
	// Voltage switched off by software marks the end of the timed operation.
	assign op_fire = wr_pc && prog_ctrl[epp_pkg::PC_HV] && !next_prog_ctrl[epp_pkg::PC_HV] && lat_valid;

	// The operation uses the mode bits held before the switch-off write.
	assign op_erase = prog_ctrl[epp_pkg::PC_ERASE];
	assign op_scope = scope_of(prog_ctrl);
	// RULE11 odd and even rows.
	assign op_both_rows = prog_ctrl[epp_pkg::PC_ODD] && prog_ctrl[epp_pkg::PC_EVEN];
	assign lat_row = row_of(lat_ofs);
	assign lat_guarded = region_guarded(lat_ofs, block_protect);
	// RULE3 bulk guard.
	assign bulk_allowed = !block_protect[epp_pkg::BP_BULK];
	// RULE4 program guard.
	assign prog_allowed = !block_protect[epp_pkg::BP_PROG];
	// RULE5 config guard normal only.
	assign cfg_allowed = special || !block_protect[epp_pkg::BP_CONFIG];

	// RULE6 each region open while its guard is clear.
	for (genvar r = 0; r < LOW_REGIONS; r++) begin : g_region_open
		assign region_open[r] = !block_protect[r];
	end
	assign region_open[LOW_REGIONS] = !block_protect[epp_pkg::BP_REGION4];

	always_comb begin
		next_block_protect = block_protect;
		for (int i = 0; i < 8; i++) begin
			if (wr_data_in[i]) begin
				next_block_protect[i] = 1'b1;
			// RULE1 one clear within window.
			end else if (special || (window_open && !cleared_once[i] && !set_locked[i])) begin
				next_block_protect[i] = 1'b0;
			end
		end
	end

	always_comb begin
		next_prog_ctrl = wr_data_in;
		// RULE12 inhibit bit not writable.
		next_prog_ctrl[epp_pkg::PC_INHIBIT] = 1'b0;
		// RULE16 voltage bit gated by latch.
		if (!prog_ctrl[epp_pkg::PC_LATCH]) begin
			next_prog_ctrl[epp_pkg::PC_HV] = 1'b0;
		end
		if (!wr_data_in[epp_pkg::PC_LATCH]) begin
			next_prog_ctrl[epp_pkg::PC_HV] = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			win_count <= '0;
		end else if (window_open) begin
			win_count <= win_count + 1'b1;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			block_protect <= epp_pkg::BLOCK_PROTECT_RESET;
			cleared_once <= 8'h00;
			set_locked <= 8'h00;
		end else if (wr_bp) begin
			block_protect <= next_block_protect;
			cleared_once <= cleared_once | (block_protect & ~next_block_protect);
			// RULE2 lock after writing one.
			// Special mode never locks, so test software can reopen a region.
			set_locked <= set_locked | (special ? 8'h00 : wr_data_in);
		end
	end

	// RULE14 erase select plain storage.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			prog_ctrl <= epp_pkg::PROGRAM_CONTROL_RESET;
			hv_enable_out <= 1'b0;
		end else if (wr_pc) begin
			prog_ctrl <= next_prog_ctrl;
			// RULE17 voltage follows command.
			// RULE24 level output, no timer.
			hv_enable_out <= next_prog_ctrl[epp_pkg::PC_HV];
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			page_map <= epp_pkg::PAGE_MAP_RESET;
		end else if (wr_en_in && (addr_in == epp_pkg::REG_PAGE_MAP)) begin
			page_map <= wr_data_in[epp_pkg::PAGE_LSB +: 4];
		end
	end

	// RULE15 latch captures writes.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			lat_valid <= 1'b0;
			lat_cfg <= 1'b0;
			lat_ofs <= '0;
			lat_data <= 8'h00;
		end else if (!prog_ctrl[epp_pkg::PC_LATCH]) begin
			lat_valid <= 1'b0;
		// RULE10 writes blocked under voltage.
		end else if (wr_en_in && !prog_ctrl[epp_pkg::PC_HV] && (hit_array || hit_cfg)) begin
			lat_valid <= 1'b1;
			lat_cfg <= hit_cfg;
			lat_ofs <= ofs;
			lat_data <= wr_data_in;
		end
	end

	// The array has no reset: it models nonvolatile cells.
	// RULE25 guarded leaves array.
	always_ff @(posedge mclk_in) begin
		if (op_fire && !lat_cfg) begin
			for (int i = 0; i < epp_pkg::ARRAY_BYTES; i++) begin
				if (op_erase) begin
					case (op_scope)
						epp_pkg::EPP_SCOPE_BULK: begin
							// Bulk erase skips guarded regions rather than refusing outright.
							if (bulk_allowed && region_open[region_of(10'(i))]) begin
								// RULE9 erased value.
								mem[i] <= epp_pkg::ERASED_BYTE;
							end
						end
						epp_pkg::EPP_SCOPE_ROW: begin
							if (bulk_allowed && !lat_guarded && (row_of(10'(i)) == lat_row)) begin
								mem[i] <= epp_pkg::ERASED_BYTE;
							end
						end
						default: begin
							if (!lat_guarded && (10'(i) == lat_ofs)) begin
								mem[i] <= epp_pkg::ERASED_BYTE;
							end
						end
					endcase
				// RULE18 scope ignored when programming.
				end else if (prog_allowed && region_open[region_of(10'(i))]) begin
					// Programming can only clear bits, so the old byte is ANDed in.
					if (op_both_rows) begin
						if ((10'(i) < epp_pkg::HALF_SPLIT) == (lat_ofs < epp_pkg::HALF_SPLIT)) begin
							mem[i] <= mem[i] & lat_data;
						end
					end else if (10'(i) == lat_ofs) begin
						mem[i] <= mem[i] & lat_data;
					end
				end
			end
		end
	end

	// RULE5 config guard normal only.
	always_ff @(posedge mclk_in) begin
		if (op_fire && lat_cfg && cfg_allowed) begin
			// Bulk and row erase never reach the config byte.
			if (op_erase) begin
				if (op_scope == epp_pkg::EPP_SCOPE_BYTE) begin
					config_cell <= epp_pkg::ERASED_BYTE;
				end
			end else if (prog_allowed) begin
				config_cell <= config_cell & lat_data;
			end
		end
	end

	// The working copy of the config byte is caught after reset release, never under the reset.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			config_loaded <= 1'b0;
			config_latch <= 8'h00;
		end else if (!config_loaded) begin
			config_loaded <= 1'b1;
			config_latch <= config_cell;
		end
	end

	// RULE7 reads bypass protection.
	always_comb begin
		next_rd = epp_pkg::READ_UNMAPPED;
		if (hit_array) begin
			next_rd = mem[ofs];
		end else if (addr_in == epp_pkg::REG_BLOCK_PROTECT) begin
			next_rd = block_protect;
		end else if (addr_in == epp_pkg::REG_PROGRAM_CONTROL) begin
			next_rd = prog_ctrl;
			// RULE12 inhibit mirrors guard.
			next_rd[epp_pkg::PC_INHIBIT] = block_protect[epp_pkg::BP_PROG];
		end else if (addr_in == epp_pkg::REG_PAGE_MAP) begin
			next_rd = {page_map, 4'h0};
		end else if (hit_cfg) begin
			next_rd = config_latch;
		end
	end

	// Read data drop back to zero between reads, so a stale byte never looks like an answer.
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= next_rd;
		end else begin
			rd_data_out <= 8'h00;
		end
	end
endmodule : epp_top

// ### tb/epp_monitor.sv
// Port checker for the EEPROM program and protect block.
`timescale 1ns/10ps
module epp_monitor (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic special_mode_in,
	input wire logic pump_clock_select_in,
	input wire logic [7:0] rd_data_out,
	input wire logic hv_enable_out,
	input wire logic pump_osc_select_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	// Only a control write can move the voltage, so decode it once.
	wire pc_wr = wr_en_in && addr_in == epp_pkg::REG_PROGRAM_CONTROL;
	a_hv_rise_cause: assert property ($rose(hv_enable_out) |-> $past(pc_wr && wr_data_in[1:0] == 2'b11))
		else $error("voltage rose without a latched voltage write");
	a_hv_fall_cause: assert property ($fell(hv_enable_out) |-> $past(pc_wr && !wr_data_in[0]))
		else $error("voltage fell without a clearing write");
	a_hv_latch_clear: assert property (pc_wr && !wr_data_in[1] |=> !hv_enable_out)
		else $error("voltage on while latch cleared");
	a_hv_level_held: assert property (hv_enable_out && !pc_wr |=> hv_enable_out)
		else $error("voltage dropped without a write");
	a_pump_follow: assert property (pump_osc_select_out == $past(pump_clock_select_in, 3))
		else $error("pump select does not follow its input");
	a_below_array: assert property (rd_en_in && addr_in == 16'h0D7F |=> rd_data_out == 8'h00)
		else $error("address below the array returned data");
	a_read_idle: assert property (!rd_en_in |=> rd_data_out == 8'h00)
		else $error("read data present without a read");
	a_ctrl_readback: assert property (rd_en_in && addr_in == epp_pkg::REG_PROGRAM_CONTROL
		|=> rd_data_out[0] == $past(hv_enable_out))
		else $error("voltage bit reads back wrong");
endmodule : epp_monitor
bind epp_top epp_monitor u_mon (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .special_mode_in(special_mode_in),
	.pump_clock_select_in(pump_clock_select_in), .rd_data_out(rd_data_out), .hv_enable_out(hv_enable_out),
	.pump_osc_select_out(pump_osc_select_out));

// ### tb/tb.sv
// Self-checking bench for the EEPROM program and protect block.
`timescale 1ns/10ps
module tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic special_mode_in = 1'b0;
	logic pump_clock_select_in = 1'b0;
	logic [7:0] rd_data_out;
	logic hv_enable_out;
	logic pump_osc_select_out;
	int bad_count = 0;
	int checked = 0;
	localparam logic [15:0] PC = epp_pkg::REG_PROGRAM_CONTROL;
	localparam logic [15:0] BP = epp_pkg::REG_BLOCK_PROTECT;
	epp_top dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .special_mode_in(special_mode_in),
		.pump_clock_select_in(pump_clock_select_in), .rd_data_out(rd_data_out), .hv_enable_out(hv_enable_out),
		.pump_osc_select_out(pump_osc_select_out));
	initial begin
		forever #25 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge mclk_in);
		wr_en_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge mclk_in);
		rd_en_in <= 1'b0;
		@(negedge mclk_in);
		chk(rd_data_out, exp, $sformatf("read %h", a));
	endtask : rd
	// Latch, store, voltage on for a few cycles, then back to read mode.
	task automatic op(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d);
		wr(PC, ctl);
		wr(a, d);
		wr(PC, ctl | 8'h01);
		@(negedge mclk_in);
		chk({7'h00, hv_enable_out}, 8'h01, "voltage on");
		repeat (4) @(posedge mclk_in);
		wr(PC, 8'h00);
		@(negedge mclk_in);
		chk({7'h00, hv_enable_out}, 8'h00, "voltage off");
	endtask : op
	task automatic t_reset_protect;
		rd(BP, epp_pkg::BLOCK_PROTECT_RESET);
		rd(16'h0D7F, 8'h00);
		wr(BP, 8'h00);
		rd(BP, 8'h00);
		wr(PC, 8'h20);
		rd(PC, 8'h00);
	endtask : t_reset_protect
	task automatic t_array;
		op(8'h06, 16'h0DC0, 8'h00);
		rd(16'h0D80, epp_pkg::ERASED_BYTE);
		rd(16'h0FFF, epp_pkg::ERASED_BYTE);
		op(8'h02, 16'h0D80, 8'hA5);
		rd(16'h0D80, 8'hA5);
		op(8'h1A, 16'h0D90, 8'h0F);
		rd(16'h0D90, 8'h0F);
		rd(16'h0D91, 8'hFF);
		wr(16'h0D82, 8'h00);
		rd(16'h0D82, 8'hFF);
		op(8'h16, 16'h0D90, 8'h00);
		rd(16'h0D90, 8'hFF);
		rd(16'h0D80, 8'hA5);
		op(8'h0E, 16'h0D85, 8'h00);
		rd(16'h0D80, 8'hFF);
	endtask : t_array
	// A second store while the voltage is on must not reach the array.
	task automatic t_hv_block;
		wr(PC, 8'h01);
		@(negedge mclk_in);
		chk({7'h00, hv_enable_out}, 8'h00, "voltage unlatched");
		wr(PC, 8'h02);
		wr(16'h0DB0, 8'h00);
		wr(PC, 8'h03);
		wr(16'h0DB1, 8'h00);
		wr(PC, 8'h00);
		rd(16'h0DB0, 8'h00);
		rd(16'h0DB1, 8'hFF);
	endtask : t_hv_block
	task automatic t_guards;
		wr(BP, 8'h01);
		op(8'h02, 16'h0D80, 8'h00);
		rd(16'h0D80, 8'hFF);
		wr(BP, 8'h00);
		rd(BP, 8'h01);
		op(8'h02, 16'h0DA0, 8'h00);
		rd(16'h0DA0, 8'h00);
		wr(BP, 8'h81);
		op(8'h0E, 16'h0DA0, 8'h00);
		rd(16'h0DA0, 8'h00);
		wr(BP, 8'hC1);
		rd(PC, 8'h20);
		op(8'h02, 16'h0DA1, 8'h00);
		rd(16'h0DA1, 8'hFF);
	endtask : t_guards
	task automatic t_pump;
		@(posedge mclk_in);
		pump_clock_select_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		@(negedge mclk_in);
		chk({7'h00, pump_osc_select_out}, 8'h01, "pump select");
		pump_clock_select_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
	endtask : t_pump
	// A clear attempted after the window has closed is ignored.
	task automatic pulse_reset;
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
	endtask : pulse_reset
	task automatic t_window;
		pulse_reset();
		repeat (70) @(posedge mclk_in);
		wr(BP, 8'h00);
		rd(BP, 8'hFF);
	endtask : t_window
	// Special mode relaxes the guards; the config copy only changes across a reset.
	task automatic t_special;
		@(posedge mclk_in);
		special_mode_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		wr(BP, 8'h10);
		rd(BP, 8'h10);
		op(8'hC2, 16'h0DA0, 8'h0F);
		rd(16'h0D81, 8'h0F);
		rd(16'h0FFF, 8'hFF);
		op(8'h16, epp_pkg::REG_CONFIG_BYTE, 8'h00);
		op(8'h02, epp_pkg::REG_CONFIG_BYTE, 8'h5A);
		@(posedge mclk_in);
		special_mode_in <= 1'b0;
		pulse_reset();
		rd(epp_pkg::REG_CONFIG_BYTE, 8'h5A);
		op(8'h16, epp_pkg::REG_CONFIG_BYTE, 8'h00);
		pulse_reset();
		rd(epp_pkg::REG_CONFIG_BYTE, 8'h5A);
		wr(16'h0037, 8'h20);
		rd(16'h2D81, 8'h0F);
		rd(16'h0D81, 8'h00);
	endtask : t_special
	task automatic end_sim;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	initial begin
		#1000000;
		bad_count++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset_protect();
		t_array();
		t_hv_block();
		t_guards();
		t_pump();
		t_window();
		t_special();
		end_sim();
	end
endmodule : tb
